/* File: hdl/tcp_pkg.sv */
// Constants and types shared by the timer capture/compare/PWM block.
package tcp_pkg;
   localparam int          NCH      = 4;
   localparam int          CW       = 16;
   localparam int          AW       = 8;
   localparam logic [7:0]  A_SC     = 8'h00;
   localparam logic [7:0]  A_CNT    = 8'h04;
   localparam logic [7:0]  A_MOD    = 8'h08;
   localparam logic [7:0]  A_CHSC   = 8'h10;
   localparam logic [7:0]  A_CHV    = 8'h30;
   localparam int          B_OVF    = 7;
   localparam int          B_CAS    = 5;
   localparam int          B_CKS    = 3;
   localparam int          B_PS     = 0;
   localparam int          B_FLAG   = 7;
   localparam int          B_MS     = 4;
   localparam int          B_EL     = 2;
   localparam logic [1:0]  CKS_OFF  = 2'h0;
   localparam logic [1:0]  CKS_BUS  = 2'h1;
   localparam logic [1:0]  CKS_FIX  = 2'h2;
   localparam logic [1:0]  CKS_EXT  = 2'h3;
   localparam logic [1:0]  EL_NONE  = 2'h0;
   localparam logic [1:0]  EL_TOG   = 2'h1;
   localparam logic [1:0]  EL_CLR   = 2'h2;
   localparam logic [1:0]  EL_SET   = 2'h3;
   localparam logic [15:0] CNT_RST  = 16'h0000;
   localparam logic [15:0] CNT_FULL = 16'hFFFF;
   localparam logic [31:0] RD_NONE  = 32'h00000000;
   typedef enum logic [2:0] {
      FN_OFF  = 3'h0,
      FN_CAP  = 3'h1,
      FN_OC   = 3'h3,
      FN_EDGE_ALIGNED_PWM = 3'h2,
      FN_CENTER_ALIGNED_PWM = 3'h6
   } tcp_fn_e;
endpackage

/* File: hdl/tcp_timer.sv */
// Timer with capture, compare, edge and center PWM channels, APB slave.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
module tcp_timer
(
   // Clock and reset.
   input  wire logic                    clk_i,
   input  wire logic                    rst_b_i,
   // APB slave.
   input  wire logic                    psel_i,
   input  wire logic                    penable_i,
   input  wire logic                    pwrite_i,
   input  wire logic [tcp_pkg::AW-1:0]  paddr_i,
   input  wire logic [31:0]             pwdata_i,
   output logic      [31:0]             prdata_o,
   output logic                         pready_o,
   output logic                         pslverr_o,
   // Count sources.
   input  wire logic                    fixed_tick_i,
   input  wire logic                    external_count_clock_i,
   // Channel pins and port override.
   input  wire logic [tcp_pkg::NCH-1:0] channel_pin_i,
   output logic      [tcp_pkg::NCH-1:0] channel_pin_o,
   output logic      [tcp_pkg::NCH-1:0] channel_pin_oe_o,
   output logic      [tcp_pkg::NCH-1:0] channel_claim_o
);

   localparam int N = tcp_pkg::NCH;

   logic             overflow_flag;
   logic             center_aligned_select;
   logic [1:0]       clock_select;
   logic [2:0]       prescale;
   logic [15:0]      modulo;
   logic [15:0]      counter_value;
   logic             cnt_dn, step_dn, cnt_upd;
   logic [6:0]       pre;
   logic [2:0]       ext_s;
   logic [1:0]       ch_ms [N];
   logic [1:0]       ch_el [N];
   logic [15:0]      ch_val [N];
   logic [N-1:0]     ch_flag, cs1, cs2, cs3;
   tcp_pkg::tcp_fn_e fn [N];
   logic [N-1:0]     match, cap_edge, sw_tmr, rel_v;
   logic             setup, wr, ext_rise, src_tick, cnt_tick, cnt_wr;
   logic [15:0]      top;
   logic             wrap_up, turn, ovf_evt, rd_hit;
   logic [31:0]      rd_data;

   // Decodes one channel's function from the shared and per-channel bits.
   function automatic tcp_pkg::tcp_fn_e ch_fn(input logic cas,
      input logic [1:0] cks, input logic [1:0] ms, input logic [1:0] el);
      if (el == tcp_pkg::EL_NONE || cks == tcp_pkg::CKS_OFF)
         return tcp_pkg::FN_OFF;
      else if (cas)
         return tcp_pkg::FN_CENTER_ALIGNED_PWM;
      else if (ms[1])
         return tcp_pkg::FN_EDGE_ALIGNED_PWM;
      else if (ms[0])
         return tcp_pkg::FN_OC;
      else
         return tcp_pkg::FN_CAP;
   endfunction

   // Mask of prescaler bits that must all be set to pass a tick.
   function automatic logic [6:0] ps_mask(input logic [2:0] ps);
      return 7'((8'h01 << ps) - 8'h01);
   endfunction

   function automatic logic is_ch(input logic [7:0] a, input logic [7:0] b);
      return a >= b && a < 8'(b + 8'(4 * N)) && a[1:0] == 2'h0;
   endfunction

   // Channel index of a word address inside a per-channel register bank.
   function automatic int ch_ix(input logic [7:0] a, input logic [7:0] b);
      return int'(8'(a - b) >> 2);
   endfunction

   assign setup  = psel_i & ~penable_i;
   assign wr     = psel_i & penable_i & pready_o & pwrite_i;
   assign cnt_wr = wr && paddr_i == tcp_pkg::A_CNT;

   // The external clock is sampled twice before its edge is detected.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         ext_s <= 3'h0;
      else
         ext_s <= {ext_s[1:0], external_count_clock_i};
   end
   assign ext_rise = ext_s[1] & ~ext_s[2];

   always_comb
   begin
      case (clock_select)
         tcp_pkg::CKS_BUS: src_tick = 1'b1;
         tcp_pkg::CKS_FIX: src_tick = fixed_tick_i;
         tcp_pkg::CKS_EXT: src_tick = ext_rise;
         default:          src_tick = 1'b0;
      endcase
   end

   // Sources are only enables; nothing here runs on another clock.
   assign cnt_tick = src_tick && (pre & ps_mask(prescale)) ==
                     ps_mask(prescale);

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         pre <= 7'h00;
      else if (cnt_wr)
         pre <= 7'h00;
      else if (src_tick)
         pre <= pre + 7'h01;
   end

   assign top = (modulo == tcp_pkg::CNT_RST || modulo == tcp_pkg::CNT_FULL)
                ? tcp_pkg::CNT_FULL : modulo;
   assign wrap_up = cnt_tick && !cnt_wr && !center_aligned_select &&
                    counter_value >= top;
   assign turn    = cnt_tick && !cnt_wr && center_aligned_select &&
                    !cnt_dn && counter_value >= top;
   assign ovf_evt = wrap_up | turn;

   // Counter; reads have no side effect, only writes restart it.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         counter_value <= tcp_pkg::CNT_RST;
         cnt_dn        <= 1'b0;
         step_dn       <= 1'b0;
         cnt_upd       <= 1'b0;
      end
      else if (cnt_wr)
      begin
         counter_value <= tcp_pkg::CNT_RST;
         cnt_dn        <= 1'b0;
         step_dn       <= 1'b0;
         cnt_upd       <= 1'b1;
      end
      else if (cnt_tick)
      begin
         cnt_upd <= 1'b1;
         if (!center_aligned_select)
         begin
            step_dn <= 1'b0;
            cnt_dn  <= 1'b0;
            if (wrap_up)
               counter_value <= tcp_pkg::CNT_RST;
            else
               counter_value <= counter_value + 16'h0001;
         end
         else if (turn || (cnt_dn && counter_value != tcp_pkg::CNT_RST))
         begin
            cnt_dn        <= 1'b1;
            step_dn       <= 1'b1;
            counter_value <= counter_value - 16'h0001;
         end
         else
         begin
            cnt_dn        <= 1'b0;
            step_dn       <= 1'b0;
            counter_value <= counter_value + 16'h0001;
         end
      end
      else
         cnt_upd <= 1'b0;
   end

   // Status and control; a new overflow beats a clearing write.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         overflow_flag         <= 1'b0;
         center_aligned_select <= 1'b0;
         clock_select          <= tcp_pkg::CKS_OFF;
         prescale              <= 3'h0;
      end
      else
      begin
         if (ovf_evt)
            overflow_flag <= 1'b1;
         else if (wr && paddr_i == tcp_pkg::A_SC && !pwdata_i[tcp_pkg::B_OVF])
            overflow_flag <= 1'b0;
         if (wr && paddr_i == tcp_pkg::A_SC)
         begin
            center_aligned_select <= pwdata_i[tcp_pkg::B_CAS];
            clock_select <= pwdata_i[tcp_pkg::B_CKS +: 2];
            prescale     <= pwdata_i[tcp_pkg::B_PS +: 3];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         modulo <= tcp_pkg::CNT_RST;
      else if (wr && paddr_i == tcp_pkg::A_MOD)
         modulo <= pwdata_i[15:0];
   end

   // Per-channel decode, compare match and synchronised capture edges.
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         fn[i] = ch_fn(center_aligned_select, clock_select, ch_ms[i],
                       ch_el[i]);
         match[i] = cnt_upd && counter_value == ch_val[i];
         sw_tmr[i] = !center_aligned_select && ch_ms[i] == 2'h1 &&
                     ch_el[i] == tcp_pkg::EL_NONE &&
                     clock_select != tcp_pkg::CKS_OFF;
         rel_v[i] = ch_el[i] == tcp_pkg::EL_NONE ||
                    clock_select == tcp_pkg::CKS_OFF;
         cap_edge[i] = fn[i] == tcp_pkg::FN_CAP &&
                       ((ch_el[i][0] && cs2[i] && !cs3[i]) ||
                        (ch_el[i][1] && !cs2[i] && cs3[i]));
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         {cs3, cs2, cs1} <= '0;
      else
         {cs3, cs2, cs1} <= {cs2, cs1, channel_pin_i};
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         for (int i = 0; i < N; i++)
         begin
            ch_ms[i] <= 2'h0;
            ch_el[i] <= tcp_pkg::EL_NONE;
         end
      else
         for (int i = 0; i < N; i++)
            if (wr && paddr_i == 8'(tcp_pkg::A_CHSC + 8'(4 * i)))
            begin
               ch_ms[i] <= pwdata_i[tcp_pkg::B_MS +: 2];
               ch_el[i] <= pwdata_i[tcp_pkg::B_EL +: 2];
            end
   end

   // Channel values and flags; hardware events beat software writes.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ch_flag <= '0;
         for (int i = 0; i < N; i++)
            ch_val[i] <= tcp_pkg::CNT_RST;
      end
      else
         for (int i = 0; i < N; i++)
         begin
            if (cap_edge[i])
               ch_val[i] <= counter_value;
            else if (wr && paddr_i == 8'(tcp_pkg::A_CHV + 8'(4 * i)))
               ch_val[i] <= pwdata_i[15:0];
            if (cap_edge[i] || (match[i] && (sw_tmr[i] ||
                (fn[i] != tcp_pkg::FN_OFF && fn[i] != tcp_pkg::FN_CAP))))
               ch_flag[i] <= 1'b1;
            else if (wr && paddr_i == 8'(tcp_pkg::A_CHSC + 8'(4 * i)) &&
                     !pwdata_i[tcp_pkg::B_FLAG])
               ch_flag[i] <= 1'b0;
         end
   end

   // Pins: while the port owns a pin its level is tracked, so a compare
   // mode that later claims it starts from the level already there.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         channel_pin_o    <= '0;
         channel_pin_oe_o <= '0;
         channel_claim_o  <= '0;
      end
      else
         for (int i = 0; i < N; i++)
         begin
            channel_claim_o[i]  <= fn[i] != tcp_pkg::FN_OFF;
            channel_pin_oe_o[i] <= fn[i] != tcp_pkg::FN_OFF &&
                                   fn[i] != tcp_pkg::FN_CAP;
            case (fn[i])
               tcp_pkg::FN_OC:
                  if (match[i])
                     case (ch_el[i])
                        tcp_pkg::EL_TOG: channel_pin_o[i] <= !channel_pin_o[i];
                        tcp_pkg::EL_CLR: channel_pin_o[i] <= 1'b0;
                        default:         channel_pin_o[i] <= 1'b1;
                     endcase
               tcp_pkg::FN_EDGE_ALIGNED_PWM:
                  if (match[i])
                     channel_pin_o[i] <= ch_el[i][0];
                  else if (cnt_upd && counter_value == tcp_pkg::CNT_RST)
                     channel_pin_o[i] <= !ch_el[i][0];
               tcp_pkg::FN_CENTER_ALIGNED_PWM:
                  if (match[i])
                     channel_pin_o[i] <= ch_el[i][0] ^ step_dn;
               default:
                  channel_pin_o[i] <= channel_pin_i[i];
            endcase
         end
   end

   // Register read multiplexer.
   always_comb
   begin
      rd_data = tcp_pkg::RD_NONE;
      rd_hit  = 1'b1;
      if (paddr_i == tcp_pkg::A_SC)
      begin
         rd_data[tcp_pkg::B_OVF]     = overflow_flag;
         rd_data[tcp_pkg::B_CAS]     = center_aligned_select;
         rd_data[tcp_pkg::B_CKS +: 2] = clock_select;
         rd_data[tcp_pkg::B_PS +: 3]  = prescale;
      end
      else if (paddr_i == tcp_pkg::A_CNT)
         rd_data[15:0] = counter_value;
      else if (paddr_i == tcp_pkg::A_MOD)
         rd_data[15:0] = modulo;
      else if (is_ch(paddr_i, tcp_pkg::A_CHSC))
      begin
         rd_data[tcp_pkg::B_FLAG]   = ch_flag[ch_ix(paddr_i, tcp_pkg::A_CHSC)];
         rd_data[tcp_pkg::B_MS +: 2] = ch_ms[ch_ix(paddr_i, tcp_pkg::A_CHSC)];
         rd_data[tcp_pkg::B_EL +: 2] = ch_el[ch_ix(paddr_i, tcp_pkg::A_CHSC)];
      end
      else if (is_ch(paddr_i, tcp_pkg::A_CHV))
         rd_data[15:0] = ch_val[ch_ix(paddr_i, tcp_pkg::A_CHV)];
      else
         rd_hit = 1'b0;
   end

   // Every access takes exactly one access cycle.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         prdata_o  <= tcp_pkg::RD_NONE;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o  <= setup;
         pslverr_o <= setup && !rd_hit;
         if (setup && !pwrite_i)
            prdata_o <= rd_data;
         else if (setup)
            prdata_o <= tcp_pkg::RD_NONE;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_count_restart: assert property (
      cnt_wr |=> counter_value == 16'h0000 && cnt_upd)
      else $error("counter not reset by write");
   a_modulo_wrap: assert property (
      wrap_up |=> counter_value == 16'h0000 && overflow_flag)
      else $error("modulo wrap wrong");
   a_count_step: assert property (
      cnt_tick && !cnt_wr && !center_aligned_select && counter_value < top
      |=> counter_value == $past(counter_value) + 16'h0001)
      else $error("count step wrong");
   a_free_run: assert property (
      cnt_tick && !cnt_wr && !center_aligned_select &&
      modulo == 16'h0000 && counter_value != 16'hFFFF
      |=> counter_value == $past(counter_value) + 16'h0001)
      else $error("zero modulo not free running");
   a_pin_release: assert property (
      ##1 (channel_pin_oe_o & $past(rel_v)) == '0)
      else $error("released pin still driven");
   a_capture_copy: assert property (
      cap_edge[2] |=> ch_val[2] == $past(counter_value) && ch_flag[2])
      else $error("capture lost");
   a_ext_sync: assert property (
      clock_select == tcp_pkg::CKS_EXT && $rose(external_count_clock_i)
      ##1 $stable(external_count_clock_i) |-> ##1 ext_rise)
      else $error("external edge not seen");
   a_edge_aligned_pwm_start: assert property (
      fn[0] == tcp_pkg::FN_EDGE_ALIGNED_PWM && ch_el[0] == tcp_pkg::EL_CLR &&
      cnt_upd && counter_value == 16'h0000 && ch_val[0] != 16'h0000
      |=> channel_pin_o[0])
      else $error("edge PWM start level wrong");
   a_oc_toggle: assert property (
      fn[0] == tcp_pkg::FN_OC && ch_el[0] == tcp_pkg::EL_TOG && match[0]
      |=> channel_pin_o[0] != $past(channel_pin_o[0]))
      else $error("compare toggle missing");
   a_center_aligned_pwm_turn: assert property (
      turn && top != 16'h0000 |=> cnt_dn &&
      counter_value == $past(counter_value) - 16'h0001)
      else $error("center count did not turn");

   c_capture: cover property (cap_edge[2]);
   c_overflow: cover property (wrap_up);
   c_center_turn: cover property (turn ##[1:100] step_dn && match[0]);
   c_edge_aligned_pwm_cycle: cover property (fn[0] == tcp_pkg::FN_EDGE_ALIGNED_PWM && match[0]);

endmodule

/* File: dv/tcp_pin_model.sv */
// Board model: resolves the channel pins and makes the external count clock.
`timescale 1ns/100ps
module tcp_pin_model
(
   // Bus clock.
   input  wire logic                    clk_i,
   // Board controls.
   input  wire logic                    ext_run_i,
   input  wire logic [tcp_pkg::NCH-1:0] board_lvl_i,
   // Timer side of the pins.
   input  wire logic [tcp_pkg::NCH-1:0] drive_i,
   input  wire logic [tcp_pkg::NCH-1:0] oe_i,
   output logic      [tcp_pkg::NCH-1:0] pin_lvl_o,
   output logic                         ext_clk_o
);
   int   div   = 0;
   logic ext_q = 1'b0;

   // A released pin shows the board level, never the last timer drive.
   assign pin_lvl_o = (oe_i & drive_i) | (~oe_i & board_lvl_i);
   assign ext_clk_o = ext_q;

   // Half period of three bus cycles keeps the rate at a sixth of bus.
   // The clock stands still while the board is not running it.
   always @(posedge clk_i)
   begin
      if (!ext_run_i)
         div <= 0;
      else if (div == 2)
      begin
         div   <= 0;
         ext_q <= ~ext_q;
      end
      else
         div <= div + 1;
   end
endmodule

/* File: dv/test_timer_capture_compare_pwm.sv */
// Self-checking bench for the timer capture/compare/PWM block.
`timescale 1ns/100ps
module test_timer_capture_compare_pwm;
   logic                    clk;
   logic                    rst_b;
   logic                    psel;
   logic                    penable;
   logic                    pwrite;
   logic [tcp_pkg::AW-1:0]  paddr;
   logic [31:0]             pwdata;
   logic [31:0]             prdata;
   logic                    pready;
   logic                    pslverr;
   logic                    fixed_tick;
   logic                    ext_clk;
   logic                    ext_run;
   logic [tcp_pkg::NCH-1:0] board_lvl;
   logic [tcp_pkg::NCH-1:0] pin_lvl;
   logic [tcp_pkg::NCH-1:0] pin_o;
   logic [tcp_pkg::NCH-1:0] pin_oe;
   logic [tcp_pkg::NCH-1:0] claim;
   logic [31:0]             q;
   logic [31:0]             c1;
   logic                    err;
   int                      fail_count;
   int                      checked;
   int                      v;
   int                      hi;
   int                      tg;

   tcp_timer i_tcp_timer
   (
      .clk_i                  (clk),
      .rst_b_i                (rst_b),
      .psel_i                 (psel),
      .penable_i              (penable),
      .pwrite_i               (pwrite),
      .paddr_i                (paddr),
      .pwdata_i               (pwdata),
      .prdata_o               (prdata),
      .pready_o               (pready),
      .pslverr_o              (pslverr),
      .fixed_tick_i           (fixed_tick),
      .external_count_clock_i (ext_clk),
      .channel_pin_i          (pin_lvl),
      .channel_pin_o          (pin_o),
      .channel_pin_oe_o       (pin_oe),
      .channel_claim_o        (claim)
   );

   tcp_pin_model i_tcp_pin_model
   (
      .clk_i       (clk),
      .ext_run_i   (ext_run),
      .board_lvl_i (board_lvl),
      .drive_i     (pin_o),
      .oe_i        (pin_oe),
      .pin_lvl_o   (pin_lvl),
      .ext_clk_o   (ext_clk)
   );

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic print_verdict;
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Requests are held until pready is sampled high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for a slave that never answers.
      do
         @(posedge clk);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic setsc(input logic cas, input logic [1:0] cks);
      apb(1'b1, tcp_pkg::A_SC, (32'(cas) << tcp_pkg::B_CAS) |
          (32'(cks) << tcp_pkg::B_CKS));
   endtask

   task automatic setch(input int n, input logic [1:0] ms,
                        input logic [1:0] el, input int val);
      apb(1'b1, tcp_pkg::A_CHV + 8'(4 * n), 32'(val));
      apb(1'b1, tcp_pkg::A_CHSC + 8'(4 * n),
          (32'(ms) << tcp_pkg::B_MS) | (32'(el) << tcp_pkg::B_EL));
   endtask

   // Counts high cycles and level changes of one pin after settling.
   task automatic measure(input int ch, input int n);
      logic last;
      hi = 0;
      tg = 0;
      repeat (16) @(posedge clk);
      last = pin_o[ch];
      repeat (n)
      begin
         @(posedge clk);
         hi += int'(pin_o[ch] === 1'b1);
         tg += int'(pin_o[ch] !== last);
         last = pin_o[ch];
      end
   endtask

   function automatic int edge_aligned_pwm_hi(int val, int m, bit inv);
      return inv ? m + 1 - val : val;
   endfunction

   function automatic int center_aligned_pwm_hi(int val, int m, bit inv);
      return inv ? 2 * (m - val) : 2 * val;
   endfunction

   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      print_verdict;
   end

   initial
   begin
      fail_count = 0;
      checked    = 0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 8'h00;
      pwdata     = 32'h0;
      fixed_tick = 1'b0;
      ext_run    = 1'b0;
      board_lvl  = 4'h0;
      rst_b      = 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      void'($urandom(34));
      @(posedge clk);
      check(claim | pin_oe, 32'h0);
      rd(8'hFC);
      check(err, 1'b1);
      check(q, 32'h0);
      setsc(1'b0, tcp_pkg::CKS_BUS);
      repeat (10) @(posedge clk);
      setsc(1'b0, tcp_pkg::CKS_OFF);
      rd(tcp_pkg::A_CNT);
      c1 = q;
      check(q != 32'h0, 1'b1);
      rd(tcp_pkg::A_CNT);
      check(q, c1);
      apb(1'b1, tcp_pkg::A_CNT, 32'h0000ABCD);
      rd(tcp_pkg::A_CNT);
      check(q, 32'h0);
      apb(1'b1, tcp_pkg::A_MOD, 32'h5);
      setsc(1'b0, tcp_pkg::CKS_BUS);
      repeat (20) @(posedge clk);
      rd(tcp_pkg::A_CNT);
      check(q <= 32'h5, 1'b1);
      rd(tcp_pkg::A_SC);
      check(q[tcp_pkg::B_OVF], 1'b1);
      apb(1'b1, tcp_pkg::A_MOD, 32'h7);
      for (int e = 2; e < 4; e++)
      begin
         setch(0, 2'h1, 2'(e), 2);
         repeat (20) @(posedge clk);
         check(pin_o[0], e == 3);
         check(pin_oe[0] & claim[0], 1'b1);
      end
      setsc(1'b0, tcp_pkg::CKS_OFF);
      repeat (2) @(posedge clk);
      check(claim[0] | pin_oe[0], 1'b0);
      board_lvl[0] <= 1'b1;
      setch(0, 2'h0, tcp_pkg::EL_NONE, 2);
      setsc(1'b0, tcp_pkg::CKS_FIX);
      setch(0, 2'h1, tcp_pkg::EL_TOG, 2);
      repeat (3) @(posedge clk);
      check(pin_o[0], 1'b1);
      setsc(1'b0, tcp_pkg::CKS_BUS);
      measure(0, 64);
      check(tg, 8);
      v = $urandom_range(6, 1);
      setch(0, 2'h2, tcp_pkg::EL_CLR, v);
      measure(0, 64);
      check(hi, 8 * edge_aligned_pwm_hi(v, 7, 1'b0));
      setch(0, 2'h2, tcp_pkg::EL_TOG, v);
      measure(0, 64);
      check(hi, 8 * edge_aligned_pwm_hi(v, 7, 1'b1));
      setch(3, 2'h0, tcp_pkg::EL_CLR, v);
      setsc(1'b1, tcp_pkg::CKS_BUS);
      measure(3, 56);
      check(hi, 4 * center_aligned_pwm_hi(v, 7, 1'b0));
      measure(0, 56);
      check(hi, 4 * center_aligned_pwm_hi(v, 7, 1'b1));
      check(claim[3] & pin_oe[3], 1'b1);
      setsc(1'b0, tcp_pkg::CKS_OFF);
      setch(0, 2'h0, tcp_pkg::EL_NONE, 0);
      setch(3, 2'h0, tcp_pkg::EL_NONE, 0);
      apb(1'b1, tcp_pkg::A_MOD, 32'h0);
      apb(1'b1, tcp_pkg::A_CNT, 32'h0);
      setch(1, 2'h1, tcp_pkg::EL_NONE, 3);
      ext_run <= 1'b1;
      setsc(1'b0, tcp_pkg::CKS_EXT);
      repeat (60) @(posedge clk);
      check(claim[1] | pin_oe[1], 1'b0);
      rd(tcp_pkg::A_CHSC + 8'h04);
      check(q[tcp_pkg::B_FLAG], 1'b1);
      rd(tcp_pkg::A_CNT);
      check(q >= 32'h8 && q <= 32'hC, 1'b1);
      ext_run <= 1'b0;
      setsc(1'b0, tcp_pkg::CKS_BUS);
      repeat (9) @(posedge clk);
      setsc(1'b0, tcp_pkg::CKS_FIX);
      rd(tcp_pkg::A_CNT);
      c1 = q;
      setch(2, 2'h0, tcp_pkg::EL_SET, 0);
      repeat (2) @(posedge clk);
      check(claim[2] & ~pin_oe[2], 1'b1);
      board_lvl[2] <= 1'b1;
      repeat (4) @(posedge clk);
      board_lvl[2] <= 1'b0;
      repeat (8) @(posedge clk);
      rd(tcp_pkg::A_CHV + 8'h08);
      check(q, c1);
      rd(tcp_pkg::A_CHSC + 8'h08);
      check(q[tcp_pkg::B_FLAG], 1'b1);
      v = $urandom_range(5, 1);
      repeat (v)
      begin
         fixed_tick <= 1'b1;
         @(posedge clk);
         fixed_tick <= 1'b0;
         @(posedge clk);
      end
      rd(tcp_pkg::A_CNT);
      check(q, c1 + 32'(v));
      rst_b <= 1'b0;
      @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      check(claim | pin_oe, 32'h0);
      rd(tcp_pkg::A_SC);
      check(q, 32'h0);
      rd(tcp_pkg::A_CNT);
      check(q, 32'h0);
      rd(tcp_pkg::A_CHSC + 8'h08);
      check(q, 32'h0);
      print_verdict;
   end
endmodule
